/* File: bench/rvs_regs_asserts.sv */
// Assertion checker for the voltage-setting register bank
`timescale 1ns/1ns
`default_nettype none
module rvs_regs_asserts
    import rvs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    input wire logic reg_hit,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire rvs_ldo_cfg_t ldo_a_cfg,
    input wire rvs_buck_cfg_t core_two_b_cfg,
    input wire rvs_buck_cfg_t core_one_b_cfg,
    input wire rvs_buck_cfg_t processor_b_cfg,
    input wire logic [11:0] core_one_b_target_mv,
    input wire logic [11:0] processor_b_target_mv
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_RD_LAT: assert property (reg_rd_valid == $past(reg_rd_en))
        else $error("read valid not one cycle after read strobe");
    AST_HIT: assert property (reg_hit == (reg_addr >= 8'hB3 && reg_addr <= 8'hB6))
        else $error("hit flag wrong for address");
    AST_WR_LDO: assert property (reg_wr_en && reg_addr == 8'hB3
        |=> ldo_a_cfg == $past(reg_wdata))
        else $error("ldo setting not written");
    AST_WR_CORE2: assert property (reg_wr_en && reg_addr == 8'hB4
        |=> core_two_b_cfg == $past(reg_wdata))
        else $error("core two setting not written");
    AST_HOLD: assert property (!reg_wr_en |=> $stable(processor_b_cfg))
        else $error("processor setting changed without write");
    AST_UNMAP: assert property (reg_wr_en && !reg_hit
        |=> $stable(ldo_a_cfg) && $stable(core_one_b_cfg))
        else $error("unmapped write changed a register");
    AST_CORE_MV: assert property (core_one_b_target_mv ==
        12'h12C + 12'h00A * $past(core_one_b_cfg.voltage_code))
        else $error("core one target wrong");
    AST_PROC_MV: assert property (processor_b_target_mv ==
        12'h212 + 12'h00A * $past(processor_b_cfg.voltage_code))
        else $error("processor target wrong");
    AST_RD_DATA: assert property (reg_rd_en && reg_addr == 8'hB5
        |=> reg_rdata == $past(core_one_b_cfg))
        else $error("read data differs from stored value");
endmodule
bind rvs_regs rvs_regs_asserts rvs_regs_asserts_i (.sys_clk, .rst_n, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_hit, .reg_rdata, .reg_rd_valid, .ldo_a_cfg, .core_two_b_cfg,
    .core_one_b_cfg, .processor_b_cfg, .core_one_b_target_mv, .processor_b_target_mv);
`default_nettype wire

/* File: bench/test_rvs_regs.sv */
// Self-checking bench for the voltage-setting register bank
`timescale 1ns/1ns
`default_nettype none
module test_rvs_regs
    import rvs_pkg::*;
();
    logic sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hit, rv;
    logic [7:0] addr = 8'hB3, wd = 8'h00, rdat;
    rvs_ldo_cfg_t lc;
    rvs_buck_cfg_t c2, c1, pc;
    logic [11:0] lm, m2, m1, pm;
    int mismatches = 0, tests_run = 0;
    logic [7:0] lw [6] = '{8'h80, 8'h42, 8'h03, 8'h54, 8'h3F, 8'hF8};
    logic [11:0] lv [6] = '{12'h384, 12'h384, 12'h3B6, 12'h708, 12'hE10, 12'hE10};
    always #20 sys_clk = ~sys_clk;
    rvs_regs rvs_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr),
        .reg_wdata(wd), .reg_rd_en(rd), .reg_hit(hit), .reg_rdata(rdat), .reg_rd_valid(rv),
        .ldo_a_cfg(lc), .core_two_b_cfg(c2), .core_one_b_cfg(c1), .processor_b_cfg(pc),
        .ldo_a_target_mv(lm), .core_two_b_target_mv(m2), .core_one_b_target_mv(m1),
        .processor_b_target_mv(pm));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk12(string n, logic [11:0] e, logic [11:0] s);
        chk8({n, " high"}, {4'h0, e[11:8]}, {4'h0, s[11:8]});
        chk8(n, e[7:0], s[7:0]);
    endtask
    task automatic wr8(logic [7:0] a, logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask
    // Checks the valid pulse in the one cycle that it stands
    task automatic rd8(logic [7:0] a, logic [7:0] e);
        @(negedge sys_clk);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk);
        rd = 1'b0;
        chk8("rd_valid", 8'h01, {7'h00, rv});
        chk8({"rdata ", $sformatf("%h", a)}, e, rdat);
        @(negedge sys_clk);
        chk8("rd_valid end", 8'h00, {7'h00, rv});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk12("ldo mv", 12'h384, lm);
        chk12("core two mv", 12'h12C, m2);
        chk12("core one mv", 12'h12C, m1);
        chk12("proc mv", 12'h212, pm);
        rst_n = 1'b1;
        // Internal reset copy needs two edges before the first request
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 4; i++)
            rd8(8'hB3 + 8'(i), 8'h00);
        $display("reset test done");
    endtask
    task automatic t_ldo;
        for (int i = 0; i < 6; i++)
        begin
            wr8(8'hB3, lw[i]);
            rd8(8'hB3, lw[i]);
            chk8("ldo cfg", lw[i], lc);
            chk12("ldo mv", lv[i], lm);
        end
        $display("ldo test done");
    endtask
    task automatic t_bucks;
        logic [7:0] d;
        for (int i = 0; i < 6; i++)
        begin
            d = (i % 2) ? 8'h7F : 8'h80;
            wr8(8'hB4 + 8'(i / 2), d);
            rd8(8'hB4 + 8'(i / 2), d);
            chk8("buck cfg", d, (i < 2) ? c2 : (i < 4) ? c1 : pc);
            chk12("buck mv", ((i < 4) ? 12'h12C : 12'h212) + 12'h00A * d[6:0],
                (i < 2) ? m2 : (i < 4) ? m1 : pm);
        end
        $display("buck test done");
    endtask
    task automatic t_unmap;
        wr8(8'hB2, 8'h11);
        wr8(8'hB7, 8'h22);
        rd8(8'hB7, 8'h00);
        chk8("hit low", 8'h00, {7'h00, hit});
        rd8(8'hB3, 8'hF8);
        chk8("hit high", 8'h01, {7'h00, hit});
        @(negedge sys_clk);
        addr = 8'hB6;
        wd = 8'h55;
        wr = 1'b1;
        rd = 1'b1;
        @(negedge sys_clk);
        {wr, rd} = 2'b00;
        chk8("old rdata", 8'h7F, rdat);
        rd8(8'hB6, 8'h55);
        $display("unmapped test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        t_reset();
        t_ldo();
        t_bucks();
        t_unmap();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: design/rvs_pkg.sv */
// Package for the regulator voltage-setting register bank
package rvs_pkg;

    // Register byte addresses
    localparam logic [7:0] RVS_ADDR_LDO_A = 8'hB3;
    localparam logic [7:0] RVS_ADDR_CORE_TWO_B = 8'hB4;
    localparam logic [7:0] RVS_ADDR_CORE_ONE_B = 8'hB5;
    localparam logic [7:0] RVS_ADDR_PROCESSOR_B = 8'hB6;
    localparam int RVS_NUM_REGS = 4;

    // Field positions
    localparam int RVS_SLEEP_BIT = 7;
    localparam int RVS_LDO_CODE_MSB = 5;
    localparam int RVS_BUCK_CODE_MSB = 6;

    // Reset values
    localparam logic [7:0] RVS_RESET_LDO_A = 8'h00;
    localparam logic [7:0] RVS_RESET_CORE_TWO_B = 8'h00;
    localparam logic [7:0] RVS_RESET_CORE_ONE_B = 8'h00;
    localparam logic [7:0] RVS_RESET_PROCESSOR_B = 8'h00;

    // Voltage code scaling, millivolts
    localparam logic [11:0] RVS_LDO_BASE_MV = 12'h0384;
    localparam logic [11:0] RVS_LDO_STEP_MV = 12'h0032;
    localparam logic [11:0] RVS_LDO_MAX_MV = 12'h0E10;
    localparam logic [5:0] RVS_LDO_FLOOR_CODE = 6'h02;
    localparam logic [5:0] RVS_LDO_TOP_CODE = 6'h38;
    localparam logic [11:0] RVS_CORE_BASE_MV = 12'h012C;
    localparam logic [11:0] RVS_PROC_BASE_MV = 12'h0212;
    localparam logic [11:0] RVS_BUCK_STEP_MV = 12'h000A;

    // Mode select meanings
    typedef enum logic {RVS_LDO_HALF_CURRENT = 1'b0, RVS_LDO_SLEEP = 1'b1} rvs_ldo_mode_t;
    typedef enum logic {RVS_BUCK_SYNC = 1'b0, RVS_BUCK_SLEEP = 1'b1} rvs_buck_mode_t;

    typedef struct packed {
        rvs_ldo_mode_t ldo_a_sleep_select;
        logic reserved;
        logic [5:0] ldo_a_voltage_code;
    } rvs_ldo_cfg_t;

    typedef struct packed {
        rvs_buck_mode_t sleep_select;
        logic [6:0] voltage_code;
    } rvs_buck_cfg_t;

endpackage

/* File: design/rvs_regs.sv */
// Register bank holding the A setting of one LDO and the B settings of three bucks
`timescale 1ns/1ns
`default_nettype none

// Contract
// R1: LDO A-setting bit 7 selects half-current (0) or sleep (1) mode.
// R2: LDO A-setting code bits 5:0, 0.90 V floor, 50 mV steps, 3.60 V top.
// R3: Each buck B-setting bit 7 selects synchronous (0) or sleep (1) mode.
// R4: Core buck B-setting codes bits 6:0, 0.30 V plus 10 mV per step.
// R5: Processor buck B-setting code 7 bits, 0.53 V plus 10 mV per step.
// R6: Buck codes give the PWM mode target voltage applied to the converter.
// R7: Registers keep written values; reads have no side effects; reserved bit reads back.
module rvs_regs
    import rvs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd_en,
    output logic reg_hit,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    output rvs_ldo_cfg_t ldo_a_cfg,
    output rvs_buck_cfg_t core_two_b_cfg,
    output rvs_buck_cfg_t core_one_b_cfg,
    output rvs_buck_cfg_t processor_b_cfg,
    output logic [11:0] ldo_a_target_mv,
    output logic [11:0] core_two_b_target_mv,
    output logic [11:0] core_one_b_target_mv,
    output logic [11:0] processor_b_target_mv
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    // Assert at once, release on the clock so no flop sees a runt recovery edge
    logic [1:0] rst_sync_q;
    logic rst_sys_n;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_sys_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode
    localparam logic [7:0] RESET_VALS [RVS_NUM_REGS] = '{
        RVS_RESET_LDO_A, RVS_RESET_CORE_TWO_B, RVS_RESET_CORE_ONE_B, RVS_RESET_PROCESSOR_B
    };
    logic [7:0] idx_full;
    logic [1:0] reg_idx;
    logic [7:0] regs_q [RVS_NUM_REGS];

    assign idx_full = reg_addr - RVS_ADDR_LDO_A;
    assign reg_idx = idx_full[1:0];
    // Only the low index bits are kept, so the hit test must gate every access
    assign reg_hit = (reg_addr >= RVS_ADDR_LDO_A) && (reg_addr <= RVS_ADDR_PROCESSOR_B);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage, all eight bits kept so the reserved bit reads back
    logic [RVS_NUM_REGS-1:0] wr_sel;

    for (genvar i = 0; i < RVS_NUM_REGS; i++)
    begin : g_reg
        assign wr_sel[i] = reg_wr_en && reg_hit && (reg_idx == 2'(i));

        always_ff @(posedge sys_clk or negedge rst_sys_n)
        begin
            if (!rst_sys_n)
            begin
                regs_q[i] <= RESET_VALS[i];
            end
            else if (wr_sel[i])
            begin
                regs_q[i] <= reg_wdata; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port, one cycle latency, no state touched
    // Valid follows every strobe, mapped or not, so a host never waits forever
    always_ff @(posedge sys_clk or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en; // R7
        end
    end

    // Data holds between reads; a read beside a write returns the old contents
    always_ff @(posedge sys_clk or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd_en)
        begin
            reg_rdata <= reg_hit ? regs_q[reg_idx] : 8'h00; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field views for the regulators
    always_comb
    begin
        ldo_a_cfg = rvs_ldo_cfg_t'(regs_q[0]); // R1
        core_two_b_cfg = rvs_buck_cfg_t'(regs_q[1]); // R3
        core_one_b_cfg = rvs_buck_cfg_t'(regs_q[2]); // R3
        processor_b_cfg = rvs_buck_cfg_t'(regs_q[3]); // R3
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Target voltages in millivolts, registered
    logic [5:0] ldo_code;
    logic [11:0] ldo_mv_d;
    logic [11:0] core_two_mv_d;
    logic [11:0] core_one_mv_d;
    logic [11:0] proc_mv_d;
    logic [6:0] core_two_code;
    logic [6:0] core_one_code;
    logic [6:0] proc_code;

    assign ldo_code = regs_q[0][RVS_LDO_CODE_MSB:0];
    assign core_two_code = regs_q[1][RVS_BUCK_CODE_MSB:0];
    assign core_one_code = regs_q[2][RVS_BUCK_CODE_MSB:0];
    assign proc_code = regs_q[3][RVS_BUCK_CODE_MSB:0];

    always_comb
    begin
        // Low codes all clamp to the floor; codes above the top hold the ceiling
        if (ldo_code <= RVS_LDO_FLOOR_CODE)
        begin
            ldo_mv_d = RVS_LDO_BASE_MV; // R2
        end
        else if (ldo_code >= RVS_LDO_TOP_CODE)
        begin
            ldo_mv_d = RVS_LDO_MAX_MV; // R2
        end
        else
        begin
            ldo_mv_d = 12'(RVS_LDO_BASE_MV
                + 12'({6'h00, ldo_code - RVS_LDO_FLOOR_CODE}) * RVS_LDO_STEP_MV); // R2
        end
    end

    always_comb
    begin
        core_two_mv_d = 12'(RVS_CORE_BASE_MV
            + 12'({5'h00, core_two_code}) * RVS_BUCK_STEP_MV); // R4
        core_one_mv_d = 12'(RVS_CORE_BASE_MV
            + 12'({5'h00, core_one_code}) * RVS_BUCK_STEP_MV); // R4
        proc_mv_d = 12'(RVS_PROC_BASE_MV
            + 12'({5'h00, proc_code}) * RVS_BUCK_STEP_MV); // R5
    end

    // Registered so the regulators never see a decode glitch
    always_ff @(posedge sys_clk or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            ldo_a_target_mv <= RVS_LDO_BASE_MV;
        end
        else
        begin
            ldo_a_target_mv <= ldo_mv_d; // R2
        end
    end

    // Bucks use these as their PWM set point whatever the sleep bit says
    always_ff @(posedge sys_clk or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            core_two_b_target_mv <= RVS_CORE_BASE_MV;
        end
        else
        begin
            core_two_b_target_mv <= core_two_mv_d; // R6
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            core_one_b_target_mv <= RVS_CORE_BASE_MV;
        end
        else
        begin
            core_one_b_target_mv <= core_one_mv_d; // R6
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sys_n)
    begin
        if (!rst_sys_n)
        begin
            processor_b_target_mv <= RVS_PROC_BASE_MV;
        end
        else
        begin
            processor_b_target_mv <= proc_mv_d; // R6
        end
    end

endmodule

`default_nettype wire
